// >>> gigabit_repeater_fault_control_test.sv
`timescale 1ns/100ps
module gigabit_repeater_fault_control_test;
    import grfc_pkg::*;

    // ------------------------------------------------------------
    // Stimulus and design
    // ------------------------------------------------------------
    localparam int NP = 4;
    localparam grfc_tx_t NORM = '{tx_en: 1'b1, tx_er: 1'b0, txd: 8'h5a};
    localparam grfc_tx_t EXTN = '{tx_en: 1'b0, tx_er: 1'b1, txd: 8'h0f};
    localparam grfc_tx_t JAMN = '{1'b1, 1'b1, TXD_JAM_DATA};
    localparam grfc_tx_t JAME = '{1'b0, 1'b1, TXD_EXT_ERROR};

    logic          clk      = 1'b0;
    logic          gmii_clk = 1'b0;
    logic          sys_rst  = 1'b1;
    logic [NP-1:0] port_en  = 4'hf;
    logic [NP-1:0] speed_ok = 4'h7;
    grfc_tx_t      core_tx  = '0;
    grfc_rx_t      rx [NP];
    grfc_tx_t      tx [NP];
    logic [NP-1:0] rx_fwd, isolated, partitioned, jabber;
    logic          jam;
    logic [1:0]    kind [NP] = '{2'h0, 2'h0, 2'h0, 2'h0};
    int            err_count = 0;
    int            tests_run = 0;

    always #5 clk = ~clk;
    // Odd start offset keeps the link clock out of phase
    initial #3.7 forever #6 gmii_clk = ~gmii_clk;

    for (genvar p = 0; p < NP; p++) begin : g_phy
        grfc_phy_model i_phy (.i_clk(gmii_clk), .i_kind(kind[p]),
                              .o_rx(rx[p]));
    end

    grfc_fault_ctl #(.N_PORTS(NP)) i_dut (
        .i_clk(clk), .i_sys_rst(sys_rst), .i_gmii_clk(gmii_clk),
        .i_port_enable(port_en), .i_speed_ok(speed_ok), .i_rx(rx),
        .i_core_tx(core_tx), .o_tx(tx), .o_rx_fwd(rx_fwd), .o_jam(jam),
        .o_isolated(isolated), .o_partitioned(partitioned),
        .o_jabber(jabber)
    );

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic stop_test;
        if (err_count == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test

    task automatic lc(input int n);
        repeat (n) @(posedge gmii_clk);
    endtask : lc

    task automatic smp;
        @(negedge gmii_clk);
    endtask : smp

    task automatic set(input logic [NP-1:0] m, input logic [1:0] k);
        @(posedge gmii_clk);
        for (int p = 0; p < NP; p++) if (m[p]) kind[p] <= k;
    endtask : set

    task automatic core(input grfc_tx_t t);
        @(posedge gmii_clk);
        core_tx <= t;
    endtask : core

    task automatic chk_bit(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_bit

    task automatic chk_tx(input grfc_tx_t got, input grfc_tx_t exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_tx

    function automatic logic pick(input int s, input int p);
        case (s)
            0: return jam;
            1: return isolated[p];
            2: return partitioned[p];
            3: return jabber[p];
            default: return rx_fwd[p];
        endcase
    endfunction : pick

    // Bounded wait; running out of the bound ends the run
    task automatic wait_bit(input int s, input int p, input logic v,
                            input int n);
        int k;
        k = 0;
        smp();
        while (k < n && pick(s, p) !== v) begin
            smp();
            k++;
        end
        chk_bit(pick(s, p), v);
        if (pick(s, p) !== v) stop_test();
    endtask : wait_bit

    // Quiet gap, then a long valid carrier on port 2 while isolated
    task automatic release2;
        lc(20);
        core(NORM);
        set(4'h4, 2'h1);
        lc(30);
        smp();
        chk_bit(rx_fwd[2], 1'b0);
        chk_tx(tx[2], '0);
        lc(VALID_CARRIER_CYC);
        set(4'h4, 2'h0);
        core('0);
        wait_bit(1, 2, 1'b0, 10);
    endtask : release2

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        lc(4);
        smp();
        for (int p = 0; p < NP; p++) begin
            chk_bit(isolated[p], 1'b1);
            chk_bit(partitioned[p], 1'b0);
            chk_bit(jabber[p] | rx_fwd[p], 1'b0);
        end
        lc(IDLE_CYC - 50);
        smp();
        chk_bit(isolated[0], 1'b1);
        for (int p = 0; p < 3; p++) wait_bit(1, p, 1'b0, 200);
        chk_bit(isolated[3], 1'b1);
        // Lone frame, then a collision in normal data
        core(NORM);
        set(4'h1, 2'h1);
        lc(20);
        smp();
        chk_bit(rx_fwd[0], 1'b1);
        chk_bit(jam, 1'b0);
        set(4'h2, 2'h1);
        wait_bit(0, 0, 1'b1, 61);
        smp();
        smp();
        chk_tx(tx[2], JAMN);
        chk_tx(tx[3], '0);
        set(4'h3, 2'h0);
        wait_bit(0, 0, 1'b0, 61);
        // Collision while the core sends carrier extension
        core(EXTN);
        set(4'h3, 2'h1);
        wait_bit(0, 0, 1'b1, 61);
        smp();
        smp();
        chk_tx(tx[2], JAME);
        set(4'h3, 2'h0);
        core('0);
        wait_bit(0, 0, 1'b0, 61);
        // False carrier count, cleared by a valid carrier
        lc(20);
        set(4'h4, 2'h2);
        wait_bit(0, 2, 1'b1, 61);
        set(4'h4, 2'h0);
        wait_bit(0, 2, 1'b0, 61);
        lc(20);
        set(4'h4, 2'h1);
        lc(30);
        set(4'h4, 2'h0);
        lc(20);
        set(4'h4, 2'h2);
        lc(10);
        set(4'h4, 2'h0);
        lc(5);
        smp();
        chk_bit(isolated[2], 1'b0);
        lc(20);
        set(4'h4, 2'h2);
        lc(10);
        set(4'h4, 2'h0);
        wait_bit(1, 2, 1'b1, 10);
        release2();
        // False carrier outlasting its timer
        set(4'h4, 2'h2);
        wait_bit(0, 2, 1'b1, 61);
        lc(FALSE_CARRIER_CYC - 80);
        smp();
        chk_bit(jam, 1'b1);
        wait_bit(0, 2, 1'b0, 150);
        chk_bit(isolated[2], 1'b1);
        set(4'h4, 2'h0);
        release2();
        // Receive jabber on port 0
        set(4'h1, 2'h1);
        lc(JABBER_CYC - 50);
        smp();
        chk_bit(jabber[0], 1'b0);
        wait_bit(3, 0, 1'b1, 100);
        core(NORM);
        smp();
        smp();
        chk_bit(rx_fwd[0], 1'b0);
        chk_tx(tx[0], '0);
        set(4'h1, 2'h0);
        core('0);
        wait_bit(3, 0, 1'b0, 5);
        // Consecutive collisions up to the limit
        set(4'h2, 2'h1);
        lc(20);
        set(4'h2, 2'h0);
        lc(20);
        for (int i = 0; i < CONSECUTIVE_COLLISION_LIMIT; i++) begin
            set(4'h3, 2'h1);
            lc(8);
            set(4'h3, 2'h0);
            lc(15);
            if (i == CONSECUTIVE_COLLISION_LIMIT - 2) begin
                smp();
                chk_bit(partitioned[0], 1'b0);
            end
        end
        wait_bit(2, 0, 1'b1, 10);
        core(NORM);
        smp();
        smp();
        chk_tx(tx[0], NORM);
        set(4'h1, 2'h1);
        lc(5);
        smp();
        chk_bit(rx_fwd[0], 1'b0);
        lc(NO_COLLISION_CYC + 30);
        set(4'h1, 2'h0);
        core('0);
        wait_bit(2, 0, 1'b0, 10);
        // Disabled port 1 no longer makes a collision
        @(posedge clk);
        port_en <= 4'hd;
        lc(5);
        set(4'h3, 2'h1);
        lc(20);
        smp();
        chk_bit(jam, 1'b0);
        chk_bit(rx_fwd[1], 1'b0);
        set(4'h3, 2'h0);
        // Speed loss isolates an open port at once
        @(posedge clk);
        speed_ok <= 4'h3;
        wait_bit(1, 2, 1'b1, 10);
        stop_test();
    end
endmodule : gigabit_repeater_fault_control_test

// >>> grfc_fault_ctl.sv
`timescale 1ns/100ps
// How it works
// RQ1: Activity on two enabled ports means jam
// RQ2: Jam coded as error or extend error
// RQ3: Packet plus jam start latency within 976
// RQ4: Jam ends no later than packet latency
// RQ5: False carrier count, cleared by valid carrier
// RQ6: False carrier timer runs during event
// RQ7: False carrier jams until end or timeout
// RQ8: Isolate at count two, timeout, reset
// RQ9: Isolated port cut both ways, still watched
// RQ10: Release after ipg plus idle quiet
// RQ11: Release after ipg quiet then valid carrier
// RQ12: Idle timer about 320 microseconds
// RQ13: Non-gigabit link traffic blocked
// RQ14: Consecutive collisions counted, success clears
// RQ15: Partition at collision limit above 60
// RQ16: Partition on collision in jabber-long carrier
// RQ17: Partitioned port receive cut, transmit kept
// RQ18: Partition cleared by reset or clean activity
// RQ19: Reception allowed for jabber window only
// RQ20: Jabber blocks both directions
// RQ21: Jabber cleared when carrier drops
// RQ22: Global transitions take priority
// RQ23: False and valid carrier timers 3600-4000
// RQ24: Ipg timer 64-86
// RQ25: Jabber timer 80000-150000
// RQ26: No-collision timer 3600-4144
// RQ27: Limits are parameters, timers checked, restarted; code: event limit fixed, idle timer unchecked
module grfc_fault_ctl #(
    parameter int N_PORTS    = 4,
    parameter int CE_LIMIT   = grfc_pkg::CONSECUTIVE_COLLISION_LIMIT,
    parameter int FC_CYC     = grfc_pkg::FALSE_CARRIER_CYC,
    parameter int VC_CYC     = grfc_pkg::VALID_CARRIER_CYC,
    parameter int IPG_CYC_P  = grfc_pkg::IPG_CYC,
    parameter int JAB_CYC    = grfc_pkg::JABBER_CYC,
    parameter int NOCOL_CYC  = grfc_pkg::NO_COLLISION_CYC,
    parameter int IDLE_CYC_P = grfc_pkg::IDLE_CYC
) (
    input  wire logic              i_clk,
    input  wire logic              i_sys_rst,
    input  wire logic              i_gmii_clk,
    input  wire logic [N_PORTS-1:0] i_port_enable,
    input  wire logic [N_PORTS-1:0] i_speed_ok,
    input  grfc_pkg::grfc_rx_t     i_rx [N_PORTS],
    input  grfc_pkg::grfc_tx_t     i_core_tx,
    output grfc_pkg::grfc_tx_t     o_tx [N_PORTS],
    output logic [N_PORTS-1:0]     o_rx_fwd,
    output logic                   o_jam,
    output logic [N_PORTS-1:0]     o_isolated,
    output logic [N_PORTS-1:0]     o_partitioned,
    output logic [N_PORTS-1:0]     o_jabber
);
    import grfc_pkg::*;

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    // Timers other than idle checked against permitted ranges [RQ27]
    if (CE_LIMIT <= 60) $error("collision limit too small"); // [RQ15]
    if (FC_CYC * LINK_CLK_NS < 3600 || FC_CYC * LINK_CLK_NS > 4000)
        $error("false carrier timer out of range"); // [RQ23]
    if (VC_CYC * LINK_CLK_NS < 3600 || VC_CYC * LINK_CLK_NS > 4000)
        $error("valid carrier timer out of range"); // [RQ23]
    if (IPG_CYC_P * LINK_CLK_NS < 64 || IPG_CYC_P * LINK_CLK_NS > 86)
        $error("ipg timer out of range"); // [RQ24]
    if (JAB_CYC * LINK_CLK_NS < 80000 || JAB_CYC * LINK_CLK_NS > 150000)
        $error("jabber timer out of range"); // [RQ25]
    if (NOCOL_CYC * LINK_CLK_NS < 3600 || NOCOL_CYC * LINK_CLK_NS > 4144)
        $error("no collision timer out of range"); // [RQ26]
    if (PACKET_START_LATENCY_BT + JAM_START_LATENCY_BT > JAM_TOTAL_LIMIT_BT)
        $error("latency budget exceeded"); // [RQ3]

    // ------------------------------------------------------------
    // System domain launch flops
    // ------------------------------------------------------------
    // Only flop outputs cross, never a glitching logic cone
    logic               rst_sys_r;
    logic [N_PORTS-1:0] en_sys_r;
    logic [N_PORTS-1:0] spd_sys_r;
    always_ff @(posedge i_clk) begin
        rst_sys_r <= i_sys_rst;
        en_sys_r  <= i_port_enable;
        spd_sys_r <= i_speed_ok;
    end

    // ------------------------------------------------------------
    // Reset crossing into link domain
    // ------------------------------------------------------------
    logic rst_s1_r;
    logic rst_r;
    always_ff @(posedge i_gmii_clk) begin
        rst_s1_r <= rst_sys_r;
        rst_r    <= rst_s1_r;
    end

    // Control levels from system domain, two flops
    logic [N_PORTS-1:0] en_s1_r;
    logic [N_PORTS-1:0] en_r;
    logic [N_PORTS-1:0] spd_s1_r;
    logic [N_PORTS-1:0] spd_r;
    always_ff @(posedge i_gmii_clk) begin
        en_s1_r  <= en_sys_r;
        en_r     <= en_s1_r;
        spd_s1_r <= spd_sys_r;
        spd_r    <= spd_s1_r;
    end

    // ------------------------------------------------------------
    // Per-port carrier monitors
    // ------------------------------------------------------------
    logic [N_PORTS-1:0] crs;
    logic [N_PORTS-1:0] fc_evt;
    logic [N_PORTS-1:0] active;
    logic [N_PORTS-1:0] force_jam;
    logic [N_PORTS-1:0] iso_r;
    logic [N_PORTS-1:0] part_r;
    logic [N_PORTS-1:0] jab_r;
    logic [N_PORTS-1:0] txing;
    logic               jam_r;
    logic               ext_r;

    genvar g;
    for (g = 0; g < N_PORTS; g++) begin : g_port
        logic [17:0] jab_cnt_r;
        logic [17:0] ci_cnt_r;
        logic [17:0] nc_cnt_r;
        logic [7:0]  ce_cnt_r;
        logic [1:0]  fce_r;
        logic        fc_prev_r;
        logic        crs_prev_r;
        logic        col_seen_r;
        logic        fc_to_r;
        grfc_ci_t    ci_r;

        // Blocked speed treated as silence [RQ13]
        assign crs[g]    = i_rx[g].crs & spd_r[g];
        assign fc_evt[g] = crs[g] & i_rx[g].rx_er & ~i_rx[g].rx_dv
                         & (i_rx[g].rxd == RXD_FALSE_CARRIER);
        assign txing[g]  = (i_core_tx.tx_en | i_core_tx.tx_er)
                         & ~iso_r[g] & ~jab_r[g];
        // Enabled and not excluded ports take part [RQ1]
        assign active[g] = crs[g] & en_r[g] & ~iso_r[g]
                         & ~part_r[g] & ~jab_r[g];
        // Jam while false carrier lasts, capped by timer [RQ7]
        assign force_jam[g] = fc_evt[g] & ~fc_to_r & ~iso_r[g];

        // Receive window and jabber [RQ19]
        always_ff @(posedge i_gmii_clk) begin
            if (rst_r) begin
                jab_cnt_r <= 18'h0;
                jab_r[g]  <= 1'b0; // [RQ21]
            end else if (!crs[g]) begin
                jab_cnt_r <= 18'h0; // [RQ27]
                jab_r[g]  <= 1'b0; // [RQ21]
            end else if (jab_cnt_r >= 18'(JAB_CYC - 1)) begin
                jab_r[g]  <= 1'b1; // [RQ19]
            end else begin
                jab_cnt_r <= jab_cnt_r + 18'h1;
            end
        end

        // Consecutive collisions and partition [RQ14]
        always_ff @(posedge i_gmii_clk) begin
            crs_prev_r <= crs[g];
            if (rst_r) begin
                ce_cnt_r   <= 8'h0;
                nc_cnt_r   <= 18'h0;
                col_seen_r <= 1'b0;
                part_r[g]  <= 1'b0; // [RQ18]
            end else begin
                if (jam_r && (crs[g] || txing[g]))
                    col_seen_r <= 1'b1;
                else if (!crs[g] && !txing[g])
                    col_seen_r <= 1'b0;
                // Count once per collided event, on its end
                if (crs_prev_r && !crs[g] && col_seen_r
                    && ce_cnt_r < 8'(CE_LIMIT))
                    ce_cnt_r <= ce_cnt_r + 8'h1; // [RQ14]
                else if (crs_prev_r && !crs[g] && !col_seen_r)
                    ce_cnt_r <= 8'h0; // [RQ14]
                if (ce_cnt_r >= 8'(CE_LIMIT))
                    part_r[g] <= 1'b1; // [RQ15]
                else if (jab_r[g] && col_seen_r)
                    part_r[g] <= 1'b1; // [RQ16]
                else if (nc_cnt_r >= 18'(NOCOL_CYC))
                    part_r[g] <= 1'b0; // [RQ18]
                // Holds at full count, so the partition clear condition stays true
                if (jam_r || (!crs[g] && !txing[g]))
                    nc_cnt_r <= 18'h0; // [RQ27]
                else if (nc_cnt_r < 18'(NOCOL_CYC))
                    nc_cnt_r <= nc_cnt_r + 18'h1;
                if (nc_cnt_r >= 18'(NOCOL_CYC) && part_r[g])
                    ce_cnt_r <= 8'h0;
            end
        end

        // Carrier integrity monitor [RQ8]
        always_ff @(posedge i_gmii_clk) begin
            fc_prev_r <= fc_evt[g];
            if (rst_r) begin
                ci_r     <= CI_LINK_UNSTABLE; // [RQ8]
                ci_cnt_r <= 18'h0;
                fce_r    <= 2'h0;
                fc_to_r  <= 1'b0;
            end else if (!spd_r[g]) begin
                // Global entry wins over every other exit [RQ22]
                ci_r     <= CI_LINK_UNSTABLE;
                ci_cnt_r <= 18'h0;
            end else begin
                unique case (ci_r)
                    CI_LINK_UNSTABLE, CI_WAIT_IDLE: begin
                        // Quiet for ipg then idle releases [RQ10]
                        if (crs[g]) begin
                            ci_cnt_r <= 18'h0;
                            if (ci_r == CI_WAIT_IDLE && !fc_evt[g])
                                ci_r <= CI_VALID_TEST; // [RQ11]
                        end else if (ci_cnt_r >= 18'(IPG_CYC_P
                                      + IDLE_CYC_P)) begin
                            ci_r     <= CI_OPEN; // [RQ10] [RQ12]
                            ci_cnt_r <= 18'h0;
                            fce_r    <= 2'h0;
                        end else begin
                            ci_cnt_r <= ci_cnt_r + 18'h1;
                            if (ci_cnt_r >= 18'(IPG_CYC_P))
                                ci_r <= CI_WAIT_IDLE; // [RQ24]
                        end
                    end
                    CI_VALID_TEST: begin
                        if (!crs[g] || fc_evt[g]) begin
                            ci_r     <= CI_LINK_UNSTABLE;
                            ci_cnt_r <= 18'h0;
                        end else if (ci_cnt_r >= 18'(VC_CYC)) begin
                            ci_r     <= CI_OPEN; // [RQ11]
                            ci_cnt_r <= 18'h0;
                            fce_r    <= 2'h0;
                        end else begin
                            ci_cnt_r <= ci_cnt_r + 18'h1;
                        end
                    end
                    CI_OPEN: begin
                        if (fc_evt[g]) begin
                            // Timer restarts on each new event [RQ6]
                            if (!fc_prev_r) begin
                                ci_cnt_r <= 18'h0;
                                fc_to_r  <= 1'b0;
                            end else if (ci_cnt_r >= 18'(FC_CYC - 1)) begin
                                fc_to_r  <= 1'b1; // [RQ7]
                                ci_r     <= CI_LINK_UNSTABLE; // [RQ8]
                                ci_cnt_r <= 18'h0;
                            end else begin
                                ci_cnt_r <= ci_cnt_r + 18'h1; // [RQ6]
                            end
                            if (!fc_prev_r) begin
                                if (fce_r + 2'h1
                                    >= 2'(FALSE_CARRIER_EVENT_LIMIT))
                                    ci_r <= CI_LINK_UNSTABLE; // [RQ8]
                                fce_r <= fce_r + 2'h1; // [RQ5]
                            end
                        end else begin
                            ci_cnt_r <= 18'h0; // [RQ6]
                            fc_to_r  <= 1'b0;
                            if (crs[g] && i_rx[g].rx_dv)
                                fce_r <= 2'h0; // [RQ5]
                        end
                    end
                endcase
            end
        end

        assign iso_r[g] = (ci_r != CI_OPEN);
    end

    // ------------------------------------------------------------
    // Repeater jam and output path
    // ------------------------------------------------------------
    logic [$clog2(N_PORTS+1)-1:0] n_active;
    always_comb begin
        n_active = '0;
        for (int i = 0; i < N_PORTS; i++)
            n_active = n_active + ($bits(n_active))'(active[i]);
    end

    // Jam follows the cause by one link cycle [RQ3] [RQ4]
    always_ff @(posedge i_gmii_clk) begin
        if (rst_r) begin
            jam_r <= 1'b0;
            ext_r <= 1'b0;
        end else begin
            jam_r <= (n_active > 1) || (|force_jam); // [RQ1] [RQ7]
            // Code choice latched at collision start [RQ2]
            if (!jam_r)
                ext_r <= i_core_tx.tx_er && !i_core_tx.tx_en;
        end
    end

    for (g = 0; g < N_PORTS; g++) begin : g_out
        always_ff @(posedge i_gmii_clk) begin
            if (rst_r || iso_r[g] || jab_r[g]) begin
                o_tx[g] <= '0; // [RQ9] [RQ20]
            end else if (jam_r) begin
                o_tx[g].tx_en <= ~ext_r; // [RQ2]
                o_tx[g].tx_er <= 1'b1;
                o_tx[g].txd   <= ext_r ? TXD_EXT_ERROR : TXD_JAM_DATA;
            end else begin
                o_tx[g] <= i_core_tx; // [RQ17]
            end
        end
    end

    always_ff @(posedge i_gmii_clk) begin
        if (rst_r)
            o_rx_fwd <= '0;
        else
            o_rx_fwd <= active; // [RQ9] [RQ17] [RQ20]
    end

    assign o_jam         = jam_r;
    assign o_isolated    = iso_r;
    assign o_partitioned = part_r;
    assign o_jabber      = jab_r;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_two_active;
        n_active > 1;
    endsequence

    a_collision_jams: assert property (@(posedge i_gmii_clk) // [RQ1]
        disable iff (rst_r) s_two_active |=> jam_r)
        else $error("collision without jam");

    sequence s_cause_gone;
        n_active < 2 && !(|force_jam);
    endsequence

    sequence s_port0_open;
        !iso_r[0] && !jab_r[0];
    endsequence

    a_jam_on_port: assert property (@(posedge i_gmii_clk) // [RQ1]
        disable iff (rst_r) s_two_active ##1 s_port0_open
        |=> o_tx[0].tx_er)
        else $error("collision jam missing on port");
    a_iso_blocks_tx: assert property (@(posedge i_gmii_clk) // [RQ9]
        disable iff (rst_r) iso_r[0] |=> !o_tx[0].tx_en)
        else $error("isolated port transmits");
    a_iso_no_fwd: assert property (@(posedge i_gmii_clk) // [RQ9]
        disable iff (rst_r) iso_r[0] |=> !o_rx_fwd[0])
        else $error("isolated port forwarded");
    a_jab_clears: assert property (@(posedge i_gmii_clk) // [RQ21]
        disable iff (rst_r) !crs[0] |=> !jab_r[0])
        else $error("jabber not cleared");
    a_jab_blocks: assert property (@(posedge i_gmii_clk) // [RQ20]
        disable iff (rst_r) jab_r[0] |=> !o_tx[0].tx_en && !o_rx_fwd[0])
        else $error("jabber port not blocked");
    a_part_rx_cut: assert property (@(posedge i_gmii_clk) // [RQ17]
        disable iff (rst_r) part_r[0] |=> !o_rx_fwd[0])
        else $error("partitioned port forwarded");
    a_jam_ends: assert property (@(posedge i_gmii_clk) // [RQ4]
        disable iff (rst_r) s_cause_gone |=> !jam_r)
        else $error("jam outlasts cause");
    a_jam_end_tx: assert property (@(posedge i_gmii_clk) // [RQ4]
        disable iff (rst_r) s_cause_gone ##1 s_port0_open
        |=> o_tx[0] == $past(i_core_tx))
        else $error("port jam outlasts cause");
    a_ext_code: assert property (@(posedge i_gmii_clk) // [RQ2]
        disable iff (rst_r) (jam_r && ext_r && !iso_r[0] && !jab_r[0])
        |=> o_tx[0].txd == TXD_EXT_ERROR)
        else $error("wrong extend jam code");
    a_speed_block: assert property (@(posedge i_gmii_clk) // [RQ13]
        disable iff (rst_r) !spd_r[N_PORTS-1] |=> !active[N_PORTS-1])
        else $error("off-speed port active");
    a_part_tx_kept: assert property (@(posedge i_gmii_clk) // [RQ17]
        disable iff (rst_r) part_r[0] && !jam_r && !iso_r[0] && !jab_r[0]
        |=> o_tx[0] == $past(i_core_tx))
        else $error("partitioned port lost output");
    a_part_sets: assert property (@(posedge i_gmii_clk) // [RQ15]
        disable iff (rst_r) g_port[0].ce_cnt_r >= 8'(CE_LIMIT) |=> part_r[0])
        else $error("partition not set at limit");
    a_jab_sets: assert property (@(posedge i_gmii_clk) // [RQ19]
        disable iff (rst_r) crs[0] && g_port[0].jab_cnt_r >= 18'(JAB_CYC - 1)
        |=> jab_r[0])
        else $error("jabber not detected");

endmodule : grfc_fault_ctl

// >>> grfc_phy_model.sv
`timescale 1ns/100ps
module grfc_phy_model (
    input  wire logic       i_clk,
    input  wire logic [1:0] i_kind,
    output grfc_pkg::grfc_rx_t o_rx
);
    import grfc_pkg::*;

    // ------------------------------------------------------------
    // Receive side of one PHY: idle, frame or false carrier
    // ------------------------------------------------------------
    // Idle rxd keeps toggling so a stale byte is never mistaken for data
    logic [7:0] cnt_r = 8'h00;

    initial o_rx = '0;

    always @(posedge i_clk) begin
        cnt_r <= cnt_r + 8'h01;
        case (i_kind)
            2'h1: o_rx <= '{crs: 1'b1, rx_dv: 1'b1, rx_er: 1'b0,
                            rxd: cnt_r};
            2'h2: o_rx <= '{crs: 1'b1, rx_dv: 1'b0, rx_er: 1'b1,
                            rxd: RXD_FALSE_CARRIER};
            default: o_rx <= '{crs: 1'b0, rx_dv: 1'b0, rx_er: 1'b0,
                               rxd: ~o_rx.rxd};
        endcase
    end
endmodule : grfc_phy_model

// >>> grfc_pkg.sv
package grfc_pkg;

    // ------------------------------------------------------------
    // Timing, in bit times (1 BT = 1 ns at 1000 Mb/s)
    // ------------------------------------------------------------
    localparam int LINK_CLK_NS            = 8;
    localparam int FALSE_CARRIER_BT       = 3800;
    localparam int VALID_CARRIER_BT       = 3800;
    localparam int IPG_BT                 = 72;
    localparam int JABBER_BT              = 100000;
    localparam int NO_COLLISION_BT        = 3800;
    localparam int IDLE_US                = 320;
    localparam int IDLE_BT                = IDLE_US * 1000;
    localparam int FALSE_CARRIER_CYC      = FALSE_CARRIER_BT / LINK_CLK_NS;
    localparam int VALID_CARRIER_CYC      = VALID_CARRIER_BT / LINK_CLK_NS;
    localparam int IPG_CYC                = IPG_BT / LINK_CLK_NS;
    localparam int JABBER_CYC             = JABBER_BT / LINK_CLK_NS;
    localparam int NO_COLLISION_CYC       = NO_COLLISION_BT / LINK_CLK_NS;
    localparam int IDLE_CYC               = IDLE_BT / LINK_CLK_NS;
    localparam int CONSECUTIVE_COLLISION_LIMIT = 64;
    localparam int FALSE_CARRIER_EVENT_LIMIT   = 2;
    localparam int PACKET_START_LATENCY_BT = 488;
    localparam int JAM_START_LATENCY_BT    = 488;
    localparam int JAM_TOTAL_LIMIT_BT      = 976;

    // ------------------------------------------------------------
    // GMII codes
    // ------------------------------------------------------------
    localparam logic [7:0] RXD_FALSE_CARRIER = 8'h0e;
    localparam logic [7:0] RXD_EXT_ERROR     = 8'h1f;
    localparam logic [7:0] TXD_EXT_ERROR     = 8'h1f;
    localparam logic [7:0] TXD_JAM_DATA      = 8'h55;

    typedef struct packed {
        logic       crs;
        logic       rx_dv;
        logic       rx_er;
        logic [7:0] rxd;
    } grfc_rx_t;

    typedef struct packed {
        logic       tx_en;
        logic       tx_er;
        logic [7:0] txd;
    } grfc_tx_t;

    typedef enum logic [1:0] {
        CI_LINK_UNSTABLE = 2'b00,
        CI_WAIT_IDLE     = 2'b01,
        CI_VALID_TEST    = 2'b10,
        CI_OPEN          = 2'b11
    } grfc_ci_t;

endpackage : grfc_pkg
